// ### fp_operand_error_flag_defines.vh
// Purpose: Shared constants of the operand-error exception unit
// Assumes: Included by bare name; definitions only
// Notes:   Offsets are byte addresses on the plain register port
`ifndef FP_OPERAND_ERROR_FLAG_DEFINES_VH
`define FP_OPERAND_ERROR_FLAG_DEFINES_VH

// Register offsets
`define REG_FP_STATUS        8'h00
`define REG_CONTROL          8'h04
`define REG_SAVED_COMMAND    8'h08
`define REG_INSTR_ADDRESS    8'h0c
`define REG_DEST_EA          8'h10
`define REG_FRAME_INFO       8'h14
`define REG_IRQ_STATUS       8'h18
`define REG_IRQ_CLEAR        8'h1c
`define REG_IRQ_ENABLE       8'h20

// Status register layout
`define EXC_BYTE_LSB         8
`define EXC_BYTE_MSB         15
`define EXC_OPERAND_ERR_BIT  5
`define EXC_BYTE_RESET       8'h00

// Control register layout
`define CTRL_OPERAND_ERROR_FLAG_EN_BIT    0
`define CTRL_RESET           1'b0

// Frame info layout
`define FI_OPCLASS_LSB       0
`define FI_OPCLASS_MSB       2
`define FI_KIND_LSB          4
`define FI_KIND_MSB          5
`define FI_POST_BIT          8
`define FI_FORMAT3_BIT       9
`define FI_IAR_VALID_BIT     10
`define FI_MOST_NEG_BIT      11

// Interrupt status layout
`define IRQ_DETECT_BIT       0
`define IRQ_TAKEN_BIT        1
`define IRQ_RESET            2'b00

// Operation kinds
`define OP_ADD               3'h0
`define OP_SUB               3'h1
`define OP_MUL               3'h2
`define OP_DIV               3'h3
`define OP_SQRT              3'h4
`define OP_MOVE              3'h5

// Destination formats
`define FMT_FP               2'h0
`define FMT_BYTE             2'h1
`define FMT_WORD             2'h2
`define FMT_LONG             2'h3

// Instruction classes
`define OPCLASS_REG_REG      3'h0
`define OPCLASS_MEM_REG      3'h2
`define OPCLASS_REG_MEM      3'h3

// State-frame kinds
`define KIND_NONE            2'h0
`define KIND_TO_REGISTER     2'h1
`define KIND_TO_MEMORY       2'h2

// Default nonsignaling NaN, all mantissa bits set
`define DEFAULT_NAN          80'h7fff_ffff_ffff_ffff_ffff

`endif

// ### fp_operand_error_flag_detect.v
// Purpose: Combinational operand-error condition decode
// Assumes: Operand class flags are valid together with op_kind
// Notes:   a is the source operand, b the destination register operand
`include "fp_operand_error_flag_defines.vh"

module fp_operand_error_flag_detect (
    input  wire [2:0]  op_kind,
    input  wire [1:0]  dest_format,
    input  wire        a_zero,
    input  wire        a_inf,
    input  wire        a_nan,
    input  wire        a_signaling,
    input  wire        a_sign,
    input  wire [15:0] a_exp,
    input  wire        a_frac_zero,
    input  wire        b_zero,
    input  wire        b_inf,
    input  wire        b_sign,
    output reg         maskable_err,
    output reg         int_err,
    output reg         int_most_neg
);

    // Lowest unbiased exponent of an out-of-range integer magnitude
    function [15:0] int_limit_exp;
        input [1:0] fmt;
        begin
            case (fmt)
                `FMT_BYTE: int_limit_exp = 16'h0007;
                `FMT_WORD: int_limit_exp = 16'h000f;
                `FMT_LONG: int_limit_exp = 16'h001f;
                default:   int_limit_exp = 16'h7fff;
            endcase
        end
    endfunction

    reg        finite_a;
    reg        exp_at_limit;
    reg        exp_over_limit;
    reg        int_dest;

    always @* begin
        finite_a       = ~a_zero & ~a_inf & ~a_nan;
        exp_at_limit   = (a_exp == int_limit_exp(dest_format));
        exp_over_limit = ($signed(a_exp) > $signed(int_limit_exp(dest_format)));
        int_dest       = (dest_format != `FMT_FP);
        maskable_err   = 1'b0;
        int_err        = 1'b0;
        int_most_neg   = 1'b0;
        case (op_kind)
            `OP_ADD:  maskable_err = a_inf & b_inf & (a_sign != b_sign);
            `OP_SUB:  maskable_err = a_inf & b_inf & (a_sign == b_sign);
            `OP_MUL:  maskable_err = (a_zero & b_inf) | (a_inf & b_zero);
            `OP_DIV:  maskable_err = (a_zero & b_zero) | (a_inf & b_inf);
            `OP_SQRT: maskable_err = a_inf | (a_sign & finite_a);
            `OP_MOVE: begin
                if (int_dest) begin
                    // The exact most negative value is trapped as well
                    int_most_neg = finite_a & a_sign & exp_at_limit & a_frac_zero;
                    int_err = (finite_a & (exp_over_limit | exp_at_limit))
                            | a_inf | (a_nan & ~a_signaling);
                end
            end
            default: begin
                maskable_err = 1'b0;
            end
        endcase
    end

endmodule

// ### fp_operand_error_exception.v
// Purpose: Operand-error detection, status, default NaN and exception posting
// Assumes: One instruction per op_valid pulse; register port never waits
// Notes:   Outputs are registered, so each answer lags its cause by one edge, irq by two
`include "fp_operand_error_flag_defines.vh"

// Notes on behaviour
// - Any operand error sets status operand bit
// - Opposite-sign infinity add, same-sign subtract flag
// - Zero times infinity flags an error
// - Integer move overflow, quiet NaN, infinity flag
// - Integer moves nonmaskable; all others maskable
// - Disabled maskable error writes default NaN, every bit set but the sign
// - Disabled maskable case: no exception, keep running
// - Enabled maskable: hold destination, pre-exception next instruction
// - Exceptions use the dedicated operand-error vector
// - Integer move error takes immediate post-exception
// - Most negative integer source also traps
// - Frame content differs by instruction class
// - Faulting instruction saved in command field
// - Memory destination address saved for format 3
// - Integer register destination loads instruction address
module fp_operand_error_exception #(
    parameter [7:0] VECTOR_NUMBER = 8'h40
) (
    input  wire        clk,
    input  wire        reset,
    input  wire        op_valid,
    input  wire [2:0]  op_kind,
    input  wire [1:0]  dest_format,
    input  wire [2:0]  opclass,
    input  wire [15:0] command_word,
    input  wire [31:0] instr_addr,
    input  wire [31:0] dest_ea,
    input  wire        dest_in_memory,
    input  wire        a_zero,
    input  wire        a_inf,
    input  wire        a_nan,
    input  wire        a_signaling,
    input  wire        a_sign,
    input  wire [15:0] a_exp,
    input  wire        a_frac_zero,
    input  wire        b_zero,
    input  wire        b_inf,
    input  wire        b_sign,
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [31:0] reg_rdata,
    output reg         nan_write,
    output reg  [79:0] nan_value,
    output reg         result_inhibit,
    output reg         exc_request,
    output reg         exc_post,
    output reg  [7:0]  exc_vector,
    output reg         irq
);

    localparam [1:0] ST_IDLE   = 2'b01;
    localparam [1:0] ST_POSTED = 2'b10;

    wire        maskable_err;
    wire        int_err;
    wire        int_most_neg;

    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [7:0]  exception_status_byte;
    reg  [7:0]  next_exception_status_byte;
    reg         operand_error_flag_enable;
    reg  [15:0] saved_command_field;
    reg  [31:0] fp_instruction_address_reg;
    reg  [31:0] saved_ea;
    reg  [2:0]  frame_opclass;
    reg  [1:0]  frame_kind;
    reg         frame_post;
    reg         frame_format3;
    reg         frame_iar_valid;
    reg         frame_most_neg;
    reg  [1:0]  irq_status;
    reg  [1:0]  next_irq_status;
    reg  [1:0]  irq_enable;
    reg  [31:0] read_value;

    fp_operand_error_flag_detect u_detect (
        .op_kind      (op_kind),
        .dest_format  (dest_format),
        .a_zero       (a_zero),
        .a_inf        (a_inf),
        .a_nan        (a_nan),
        .a_signaling  (a_signaling),
        .a_sign       (a_sign),
        .a_exp        (a_exp),
        .a_frac_zero  (a_frac_zero),
        .b_zero       (b_zero),
        .b_inf        (b_inf),
        .b_sign       (b_sign),
        .maskable_err (maskable_err),
        .int_err      (int_err),
        .int_most_neg (int_most_neg)
    );

    // An instruction arriving while an error is posted is trapped before it
    // runs, so its own operands are not examined
    wire take_pre = op_valid & state[1];
    wire detect   = op_valid & ~take_pre & (maskable_err | int_err);

    // Integer destinations bypass the enable entirely
    wire is_nonmaskable = int_err;
    wire mask_dis = detect & ~is_nonmaskable & ~operand_error_flag_enable;
    wire mask_en  = detect & ~is_nonmaskable & operand_error_flag_enable;
    wire post_now = detect & is_nonmaskable;

    wire wr_status  = reg_write & (reg_addr == `REG_FP_STATUS);
    wire wr_control = reg_write & (reg_addr == `REG_CONTROL);
    wire wr_iclear  = reg_write & (reg_addr == `REG_IRQ_CLEAR);
    wire wr_ienable = reg_write & (reg_addr == `REG_IRQ_ENABLE);

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (mask_en) begin
                    next_state = ST_POSTED;
                end
            end
            ST_POSTED: begin
                if (take_pre) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Set wins over a software write in the same cycle
    always @* begin
        next_exception_status_byte = exception_status_byte;
        if (wr_status) begin
            next_exception_status_byte = reg_wdata[`EXC_BYTE_MSB:`EXC_BYTE_LSB];
        end
        if (detect) begin
            next_exception_status_byte[`EXC_OPERAND_ERR_BIT] = 1'b1;
        end
    end

    always @* begin
        next_irq_status = irq_status;
        if (wr_iclear) begin
            next_irq_status = irq_status & ~reg_wdata[1:0];
        end
        if (detect) begin
            next_irq_status[`IRQ_DETECT_BIT] = 1'b1;
        end
        if (take_pre | post_now) begin
            next_irq_status[`IRQ_TAKEN_BIT] = 1'b1;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            state                 <= ST_IDLE;
            exception_status_byte <= `EXC_BYTE_RESET;
            operand_error_flag_enable          <= `CTRL_RESET;
            irq_status            <= `IRQ_RESET;
            irq_enable            <= `IRQ_RESET;
            irq                   <= 1'b0;
        end else begin
            state                 <= next_state;
            exception_status_byte <= next_exception_status_byte;
            irq_status            <= next_irq_status;
            irq                   <= |(irq_status & irq_enable);
            if (wr_control) begin
                operand_error_flag_enable <= reg_wdata[`CTRL_OPERAND_ERROR_FLAG_EN_BIT];
            end
            if (wr_ienable) begin
                irq_enable <= reg_wdata[1:0];
            end
        end
    end

    // Datapath answers; nan_value is a flop so the output is registered
    always @(posedge clk) begin
        if (reset) begin
            nan_write      <= 1'b0;
            nan_value      <= `DEFAULT_NAN;
            result_inhibit <= 1'b0;
            exc_request    <= 1'b0;
            exc_post       <= 1'b0;
            exc_vector     <= VECTOR_NUMBER;
        end else begin
            nan_value      <= `DEFAULT_NAN;
            nan_write      <= mask_dis;
            // Disabled case raises nothing and never inhibits
            result_inhibit <= mask_en | post_now;
            exc_request    <= take_pre | post_now;
            exc_vector     <= VECTOR_NUMBER;
            if (take_pre | post_now) begin
                exc_post <= post_now;
            end
        end
    end

    // State frame is captured at detection and held until the next error
    always @(posedge clk) begin
        if (reset) begin
            saved_command_field        <= 16'h0000;
            fp_instruction_address_reg <= 32'h0000_0000;
            saved_ea                   <= 32'h0000_0000;
            frame_opclass              <= 3'h0;
            frame_kind                 <= `KIND_NONE;
            frame_post                 <= 1'b0;
            frame_format3              <= 1'b0;
            frame_iar_valid            <= 1'b0;
            frame_most_neg             <= 1'b0;
        end else if (detect) begin
            saved_command_field <= command_word;
            frame_opclass       <= opclass;
            frame_post          <= post_now;
            frame_most_neg      <= int_most_neg;
            case (opclass)
                `OPCLASS_REG_REG: frame_kind <= `KIND_TO_REGISTER;
                `OPCLASS_MEM_REG: frame_kind <= `KIND_TO_REGISTER;
                `OPCLASS_REG_MEM: frame_kind <= `KIND_TO_MEMORY;
                default:          frame_kind <= `KIND_NONE;
            endcase
            frame_format3 <= post_now & dest_in_memory;
            if (post_now & dest_in_memory) begin
                saved_ea <= dest_ea;
            end
            // The operation word names the integer destination register
            frame_iar_valid <= post_now & ~dest_in_memory;
            if (post_now & ~dest_in_memory) begin
                fp_instruction_address_reg <= instr_addr;
            end
        end
    end

    always @* begin
        read_value = 32'h0000_0000;
        case (reg_addr)
            `REG_FP_STATUS: begin
                read_value[`EXC_BYTE_MSB:`EXC_BYTE_LSB] = exception_status_byte;
            end
            `REG_CONTROL: begin
                read_value[`CTRL_OPERAND_ERROR_FLAG_EN_BIT] = operand_error_flag_enable;
            end
            `REG_SAVED_COMMAND: begin
                read_value[15:0] = saved_command_field;
            end
            `REG_INSTR_ADDRESS: begin
                read_value = fp_instruction_address_reg;
            end
            `REG_DEST_EA: begin
                read_value = saved_ea;
            end
            `REG_FRAME_INFO: begin
                read_value[`FI_OPCLASS_MSB:`FI_OPCLASS_LSB] = frame_opclass;
                read_value[`FI_KIND_MSB:`FI_KIND_LSB]       = frame_kind;
                read_value[`FI_POST_BIT]                    = frame_post;
                read_value[`FI_FORMAT3_BIT]                 = frame_format3;
                read_value[`FI_IAR_VALID_BIT]               = frame_iar_valid;
                read_value[`FI_MOST_NEG_BIT]                = frame_most_neg;
            end
            `REG_IRQ_STATUS: begin
                read_value[1:0] = irq_status;
            end
            `REG_IRQ_ENABLE: begin
                read_value[1:0] = irq_enable;
            end
            default: begin
                read_value = 32'h0000_0000;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            reg_rdata <= read_value;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule

// ### fp_operand_error_flag_properties.sv
// Purpose: Port-level checks of the operand-error exception unit
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every instance of the top module
`include "fp_operand_error_flag_defines.vh"
module fp_operand_error_flag_checker #(
    parameter [7:0] VECTOR_NUMBER = 8'h40
) (
    input wire        clk,
    input wire        reset,
    input wire        op_valid,
    input wire [2:0]  op_kind,
    input wire        reg_read,
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_rdata,
    input wire        nan_write,
    input wire [79:0] nan_value,
    input wire        result_inhibit,
    input wire        exc_request,
    input wire        exc_post,
    input wire [7:0]  exc_vector
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence post_trap;
        exc_request && exc_post && result_inhibit;
    endsequence
    sequence move_taken;
        $past(op_valid) && $past(op_kind) == `OP_MOVE;
    endsequence

    AST_POST_TRAP: assert property (exc_request && exc_post |-> post_trap ##0 move_taken)
        else $error("post exception without a move");
    AST_VECTOR: assert property (exc_request |-> exc_vector == VECTOR_NUMBER)
        else $error("wrong exception vector");
    AST_NAN_VALUE: assert property (nan_write |-> nan_value == `DEFAULT_NAN)
        else $error("default NaN value wrong");
    AST_NAN_QUIET: assert property (nan_write |-> !exc_request && !result_inhibit)
        else $error("default NaN with exception");
    AST_NAN_CAUSE: assert property (nan_write |-> $past(op_valid) && $past(op_kind) != `OP_MOVE)
        else $error("default NaN without maskable op");
    AST_PRE_CAUSE: assert property (exc_request && !exc_post |-> $past(op_valid) && !result_inhibit)
        else $error("pre exception without next op");
    AST_POST_HOLD: assert property (!exc_request |-> $stable(exc_post))
        else $error("exception type changed alone");
    AST_RDATA_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");
    AST_CLEAR_RO: assert property (reg_read && reg_addr == `REG_IRQ_CLEAR |=> reg_rdata == 32'h0000_0000)
        else $error("clear register reads nonzero");
endmodule

bind fp_operand_error_exception fp_operand_error_flag_checker #(.VECTOR_NUMBER(VECTOR_NUMBER)) chk_i (
    .clk, .reset, .op_valid, .op_kind, .reg_read, .reg_addr, .reg_rdata, .nan_write,
    .nan_value, .result_inhibit, .exc_request, .exc_post, .exc_vector
);

// ### test_fp_operand_error_exception.sv
// Purpose: Self-checking bench for the operand-error exception unit
// Assumes: Register port answers one cycle after the read strobe
// Notes:   Vector set off its default so a hard-wired value shows
`include "fp_operand_error_flag_defines.vh"
module test_fp_operand_error_exception;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        op_valid = 1'b0;
    logic [2:0]  op_kind = 3'h0;
    logic [1:0]  dest_format = 2'h0;
    logic [2:0]  opclass = 3'h0;
    logic [15:0] command_word = 16'h0000;
    logic        dest_in_memory = 1'b0;
    logic [8:0]  flags = 9'h000;
    logic [15:0] a_exp = 16'h0000;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    wire  [31:0] reg_rdata;
    wire  [79:0] nan_value;
    wire  [7:0]  exc_vector;
    wire         nan_write, result_inhibit, exc_request, exc_post, irq;
    int          bad_count = 0;
    int          total_checks = 0;
    // Flags: a_zero a_inf a_nan a_signaling a_sign a_frac_zero b_zero b_inf b_sign
    logic [2:0]  tk [0:9] = '{`OP_ADD, `OP_ADD, `OP_SUB, `OP_SUB, `OP_MUL,
                              `OP_DIV, `OP_DIV, `OP_SQRT, `OP_SQRT, `OP_SQRT};
    logic [8:0]  tf [0:9] = '{9'h083, 9'h082, 9'h082, 9'h083, 9'h102,
                              9'h104, 9'h082, 9'h010, 9'h080, 9'h110};
    logic [9:0]  te = 10'h1f5;

    fp_operand_error_exception #(.VECTOR_NUMBER(8'h5a)) uut (
        .clk(clk), .reset(reset), .op_valid(op_valid), .op_kind(op_kind),
        .dest_format(dest_format), .opclass(opclass), .command_word(command_word),
        .instr_addr(32'h0000_4000), .dest_ea(32'h0000_1234), .dest_in_memory(dest_in_memory),
        .a_zero(flags[8]), .a_inf(flags[7]), .a_nan(flags[6]), .a_signaling(flags[5]),
        .a_sign(flags[4]), .a_exp(a_exp), .a_frac_zero(flags[3]), .b_zero(flags[2]),
        .b_inf(flags[1]), .b_sign(flags[0]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .nan_write(nan_write), .nan_value(nan_value), .result_inhibit(result_inhibit),
        .exc_request(exc_request), .exc_post(exc_post), .exc_vector(exc_vector), .irq(irq)
    );

    always #20 clk = ~clk;

    task automatic finish_test;
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: value %h, wanted %h", $time, g, e);
        end
    endtask

    task automatic chk_out(input logic [3:0] g, input logic [3:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: nan/inhibit/request/post %b, wanted %b", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk_reg(reg_rdata, e);
    endtask

    task automatic setup(input logic [2:0] c, input logic m, input logic [15:0] w);
        @(posedge clk);
        opclass <= c;
        dest_in_memory <= m;
        command_word <= w;
    endtask

    task automatic op(input logic [2:0] k, input logic [1:0] f, input logic [8:0] fl,
                      input logic [15:0] ex, input logic [3:0] e);
        @(posedge clk);
        op_valid <= 1'b1;
        op_kind <= k;
        dest_format <= f;
        flags <= fl;
        a_exp <= ex;
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk_out({nan_write, result_inhibit, exc_request, exc_post}, e);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(`REG_FP_STATUS, 32'h0000_0000);
        rd(`REG_CONTROL, 32'h0000_0000);
        rd(`REG_IRQ_STATUS, 32'h0000_0000);
        rd(`REG_IRQ_ENABLE, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        chk_reg({24'h00_0000, exc_vector}, 32'h0000_005a);
        chk_reg(nan_value[79:48], 32'h7fff_ffff);
        chk_reg(nan_value[47:16], 32'hffff_ffff);
        chk_reg({16'h0000, nan_value[15:0]}, 32'h0000_ffff);
        for (int i = 0; i < 10; i++) begin
            op(tk[i], `FMT_FP, tf[i], 16'h0000, {te[i], 3'b000});
        end
        rd(`REG_FP_STATUS, 32'h0000_2000);
        rd(`REG_IRQ_STATUS, 32'h0000_0001);
        chk_reg({31'h0, irq}, 32'h0000_0000);
        wr(`REG_IRQ_ENABLE, 32'h0000_0001);
        rd(`REG_IRQ_STATUS, 32'h0000_0001);
        chk_reg({31'h0, irq}, 32'h0000_0001);
        rd(`REG_IRQ_CLEAR, 32'h0000_0000);
        wr(`REG_IRQ_CLEAR, 32'h0000_0001);
        rd(`REG_IRQ_STATUS, 32'h0000_0000);
        chk_reg({31'h0, irq}, 32'h0000_0000);
        wr(`REG_FP_STATUS, 32'h0000_0000);
        rd(`REG_FP_STATUS, 32'h0000_0000);
        setup(`OPCLASS_REG_MEM, 1'b1, 16'h5a01);
        op(`OP_MOVE, `FMT_LONG, 9'h000, 16'h001f, 4'b0111);
        rd(`REG_FRAME_INFO, 32'h0000_0323);
        rd(`REG_DEST_EA, 32'h0000_1234);
        rd(`REG_SAVED_COMMAND, 32'h0000_5a01);
        rd(`REG_FP_STATUS, 32'h0000_2000);
        op(`OP_MOVE, `FMT_WORD, 9'h000, 16'h000e, 4'b0001);
        op(`OP_MOVE, `FMT_BYTE, 9'h080, 16'h0000, 4'b0111);
        setup(`OPCLASS_REG_MEM, 1'b0, 16'h5a02);
        op(`OP_MOVE, `FMT_LONG, 9'h018, 16'h001f, 4'b0111);
        rd(`REG_FRAME_INFO, 32'h0000_0d23);
        rd(`REG_INSTR_ADDRESS, 32'h0000_4000);
        op(`OP_MOVE, `FMT_LONG, 9'h040, 16'h0000, 4'b0111);
        op(`OP_MOVE, `FMT_LONG, 9'h060, 16'h0000, 4'b0001);
        rd(`REG_IRQ_STATUS, 32'h0000_0003);
        wr(`REG_IRQ_CLEAR, 32'h0000_0003);
        wr(`REG_CONTROL, 32'h0000_0001);
        setup(`OPCLASS_REG_REG, 1'b0, 16'h5a03);
        op(`OP_MUL, `FMT_FP, 9'h102, 16'h0000, 4'b0101);
        rd(`REG_FRAME_INFO, 32'h0000_0010);
        rd(`REG_SAVED_COMMAND, 32'h0000_5a03);
        rd(`REG_IRQ_STATUS, 32'h0000_0001);
        op(`OP_ADD, `FMT_FP, 9'h000, 16'h0000, 4'b0010);
        rd(`REG_IRQ_STATUS, 32'h0000_0003);
        chk_reg({31'h0, irq}, 32'h0000_0001);
        op(`OP_ADD, `FMT_FP, 9'h000, 16'h0000, 4'b0000);
        // Memory-to-register class, then a move swallowed by the pending trap
        setup(`OPCLASS_MEM_REG, 1'b0, 16'h5a04);
        op(`OP_DIV, `FMT_FP, 9'h104, 16'h0000, 4'b0100);
        rd(`REG_FRAME_INFO, 32'h0000_0012);
        op(`OP_MOVE, `FMT_LONG, 9'h080, 16'h0000, 4'b0010);
        // Enable set, yet the integer move still posts at once
        op(`OP_MOVE, `FMT_LONG, 9'h080, 16'h0000, 4'b0111);
        finish_test();
    end

    // Run needs about 110 cycles; cut off far beyond that
    initial begin
        #100000;
        bad_count++;
        finish_test();
    end
endmodule
